/* File: include/pbsc_regs.svh */
// constants of the pipelined burst memory control block
`ifndef PBSC_REGS_SVH
`define PBSC_REGS_SVH

// command to data distance in clock edges
`define PBSC_LAT_CYCLES 2
// address width of the wide organisation
`define PBSC_ADDR_W 18
// byte lanes of the wide organisation
`define PBSC_LANES 4
// bits per lane, eight data plus one parity
`define PBSC_LANE_W 9
// low address bits walked by the burst counter
`define PBSC_BEAT_W 2
// level of the burst order pin that picks interleaved order
`define PBSC_ORDER_INTERLEAVED 1'h1
// data bus output enable after reset, released
`define PBSC_OE_N_RST 1'h1

`endif

/* File: include/pbsc_pkg.sv */
// types shared by the pipelined burst memory control block
package pbsc_pkg;

   // direction of the burst in progress, fixed when the address is loaded
   typedef enum logic [1:0] {
      BST_IDLE,
      BST_READ,
      BST_WRITE
   } pbsc_burst_e;

   // decoded kind of the cycle taken at a clock edge
   typedef enum logic [2:0] {
      CYC_SUSPEND,
      CYC_LOAD_READ,
      CYC_LOAD_WRITE,
      CYC_BURST,
      CYC_DESELECT,
      CYC_IDLE
   } pbsc_cycle_e;

   // control pins sampled together at each edge
   typedef struct packed {
      logic clock_enable_n;
      logic chip_select_one_n;
      logic chip_select_two_n;
      logic chip_select_two;
      logic read_write;
      logic advance_or_load;
      logic burst_order_select;
   } pbsc_ctl_s;

endpackage

/* File: design/pbsc_mem.sv */
// lane-writable storage array with registered read data and write bypass
`timescale 1ns/10ps
`include "pbsc_regs.svh"

module pbsc_mem #(
   parameter int ADDR_W = `PBSC_ADDR_W,
   parameter int LANES  = `PBSC_LANES,
   parameter int LANE_W = `PBSC_LANE_W
) (
   input  wire logic                    clk,
   input  wire logic                    en,
   input  wire logic [ADDR_W-1:0]       rd_addr,
   input  wire logic [LANES-1:0]        wr_lane,
   input  wire logic [ADDR_W-1:0]       wr_addr,
   input  wire logic [LANES*LANE_W-1:0] wr_data,
   output logic      [LANES*LANE_W-1:0] rd_data
);

   genvar g;

   // one storage column per lane; a frozen edge neither reads nor writes
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [LANE_W-1:0] store_r [0:(2**ADDR_W)-1];
         logic [LANE_W-1:0] rd_r;

         always_ff @(posedge clk) begin
            if (en) begin
               if (wr_lane[g]) begin
                  store_r[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
               end
               // a read of the word being written sees the new lane
               if (wr_lane[g] && (wr_addr == rd_addr)) begin
                  rd_r <= wr_data[g*LANE_W +: LANE_W];
               end else begin
                  rd_r <= store_r[rd_addr];
               end
            end
         end

         assign rd_data[g*LANE_W +: LANE_W] = rd_r;
      end
   endgenerate

endmodule

/* File: design/pbsc_top.sv */
// command decode, burst counter and data pipeline of the burst memory
`timescale 1ns/10ps
`include "pbsc_regs.svh"

module pbsc_top #(
   parameter int ADDR_W = `PBSC_ADDR_W,
   parameter int LANES  = `PBSC_LANES,
   parameter int LANE_W = `PBSC_LANE_W
) (
   REF_CLK,
   RST_B,
   CLOCK_ENABLE_N,
   CHIP_SELECT_ONE_N,
   CHIP_SELECT_TWO_N,
   CHIP_SELECT_TWO,
   READ_WRITE,
   ADVANCE_OR_LOAD,
   BURST_ORDER_SELECT,
   BYTE_WRITE_STROBE_N,
   ADDR,
   DQ_IN,
   DQ_OUT,
   DQ_OE_N,
   CYCLE_KIND,
   BURST_ACTIVE
);

   localparam int DW = LANES * LANE_W;
   localparam int BW = `PBSC_BEAT_W;

   input  wire logic                  REF_CLK;
   input  wire logic                  RST_B;
   input  wire logic                  CLOCK_ENABLE_N;
   input  wire logic                  CHIP_SELECT_ONE_N;
   input  wire logic                  CHIP_SELECT_TWO_N;
   input  wire logic                  CHIP_SELECT_TWO;
   input  wire logic                  READ_WRITE;
   input  wire logic                  ADVANCE_OR_LOAD;
   input  wire logic                  BURST_ORDER_SELECT;
   input  wire logic [LANES-1:0]      BYTE_WRITE_STROBE_N;
   input  wire logic [ADDR_W-1:0]     ADDR;
   input  wire logic [DW-1:0]         DQ_IN;
   output logic      [DW-1:0]         DQ_OUT;
   output logic                       DQ_OE_N;
   output pbsc_pkg::pbsc_cycle_e      CYCLE_KIND;
   output logic                       BURST_ACTIVE;

   // one memory access travelling down the pipeline
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  lane;
   } pbsc_cmd_s;

   // whole state of the block
   typedef struct packed {
      pbsc_pkg::pbsc_burst_e burst;
      logic                  active;
      logic [ADDR_W-1:0]     base;
      logic [BW-1:0]         beat;
      pbsc_cmd_s             s1;
      pbsc_cmd_s             s2;
      logic [DW-1:0]         dq_out;
      logic                  dq_oe_n;
      pbsc_pkg::pbsc_cycle_e kind;
   } pbsc_state_s;

   pbsc_state_s         st_r;
   pbsc_state_s         st_nxt;
   pbsc_pkg::pbsc_ctl_s ctl;
   pbsc_pkg::pbsc_cycle_e cyc;
   logic                selected;
   logic [BW-1:0]       beat_next;
   logic [BW-1:0]       low_next;
   logic [DW-1:0]       rd_data;
   logic [LANES-1:0]    wr_lane;

   // control pins gathered into one word
   assign ctl = '{
      clock_enable_n:     CLOCK_ENABLE_N,
      chip_select_one_n:  CHIP_SELECT_ONE_N,
      chip_select_two_n:  CHIP_SELECT_TWO_N,
      chip_select_two:    CHIP_SELECT_TWO,
      read_write:         READ_WRITE,
      advance_or_load:    ADVANCE_OR_LOAD,
      burst_order_select: BURST_ORDER_SELECT
   };

   // all three selects must be active on a load, any inactive one deselects a load; advance ignores them
   assign selected = !ctl.chip_select_one_n && !ctl.chip_select_two_n
                     && ctl.chip_select_two;

   // next beat wraps back to the loaded start after the fourth
   assign beat_next = st_r.beat + 2'h1;

   // low address bits of the next beat in the chosen order
   always_comb begin
      if (ctl.burst_order_select == `PBSC_ORDER_INTERLEAVED) begin
         low_next = st_r.base[BW-1:0] ^ beat_next;
      end else begin
         low_next = st_r.base[BW-1:0] + beat_next;
      end
   end

   // decode of the cycle offered at this edge
   always_comb begin
      if (ctl.clock_enable_n) begin
         cyc = pbsc_pkg::CYC_SUSPEND;
      end else if (!ctl.advance_or_load) begin
         if (!selected) begin
            cyc = pbsc_pkg::CYC_DESELECT;
         end else if (ctl.read_write) begin
            cyc = pbsc_pkg::CYC_LOAD_READ;
         end else begin
            cyc = pbsc_pkg::CYC_LOAD_WRITE;
         end
      end else if (st_r.burst != pbsc_pkg::BST_IDLE) begin
         cyc = pbsc_pkg::CYC_BURST;
      end else begin
         cyc = pbsc_pkg::CYC_IDLE;
      end
   end

   // next state: pipeline shift, burst bookkeeping and data bus
   always_comb begin
      st_nxt = st_r;
      if (!RST_B) begin
         // bus released and pipeline empty after the first edge
         st_nxt = '0;
         st_nxt.burst = pbsc_pkg::BST_IDLE;
         st_nxt.kind = pbsc_pkg::CYC_IDLE;
         st_nxt.dq_oe_n = `PBSC_OE_N_RST;
      end else if (cyc != pbsc_pkg::CYC_SUSPEND) begin
         st_nxt.kind = cyc;
         // second stage: data moves two edges after the command
         st_nxt.s2 = st_r.s1;
         st_nxt.dq_oe_n = !(st_r.s2.valid && !st_r.s2.write);
         if (st_r.s2.valid && !st_r.s2.write) begin
            st_nxt.dq_out = rd_data;
         end
         st_nxt.s1 = '0;
         unique case (cyc)
            pbsc_pkg::CYC_LOAD_READ, pbsc_pkg::CYC_LOAD_WRITE: begin
               // external address loaded, direction caught for the burst
               st_nxt.base = ADDR;
               st_nxt.beat = '0;
               st_nxt.burst = ctl.read_write ? pbsc_pkg::BST_READ
                                             : pbsc_pkg::BST_WRITE;
               st_nxt.s1.valid = 1'h1;
               st_nxt.s1.write = !ctl.read_write;
               st_nxt.s1.addr = ADDR;
               st_nxt.s1.lane = ~BYTE_WRITE_STROBE_N;
            end
            pbsc_pkg::CYC_BURST: begin
               // internal address, read/write pin ignored
               st_nxt.beat = beat_next;
               st_nxt.s1.valid = 1'h1;
               st_nxt.s1.write = (st_r.burst == pbsc_pkg::BST_WRITE);
               st_nxt.s1.addr = {st_r.base[ADDR_W-1:BW], low_next};
               st_nxt.s1.lane = ~BYTE_WRITE_STROBE_N;
            end
            pbsc_pkg::CYC_DESELECT: begin
               // no new access; earlier ones still finish
               st_nxt.burst = pbsc_pkg::BST_IDLE;
            end
            pbsc_pkg::CYC_IDLE: begin
               // advance without a burst leaves the counter alone
               st_nxt.burst = pbsc_pkg::BST_IDLE;
            end
            pbsc_pkg::CYC_SUSPEND: begin
               st_nxt.burst = st_r.burst;
            end
         endcase
         // burst flag kept in its own flop so the port needs no logic
         st_nxt.active = (st_nxt.burst != pbsc_pkg::BST_IDLE);
      end
   end

   // state register; a suspended edge reloads the old state
   always_ff @(posedge REF_CLK) begin
      st_r <= st_nxt;
   end

   // lanes written at the second data edge; strobes only matter on writes
   always_comb begin
      if (st_r.s2.valid && st_r.s2.write) begin
         wr_lane = st_r.s2.lane;
      end else begin
         wr_lane = '0;
      end
   end

   // storage array, frozen together with the pipeline
   pbsc_mem #(
      .ADDR_W (ADDR_W),
      .LANES  (LANES),
      .LANE_W (LANE_W)
   ) u_mem (
      .clk     (REF_CLK),
      .en      (!CLOCK_ENABLE_N && RST_B),
      .rd_addr (st_r.s1.addr),
      .wr_lane (wr_lane),
      .wr_addr (st_r.s2.addr),
      .wr_data (DQ_IN),
      .rd_data (rd_data)
   );

   // outputs straight from the state register
   assign DQ_OUT = st_r.dq_out;
   assign DQ_OE_N = st_r.dq_oe_n;
   assign CYCLE_KIND = st_r.kind;
   assign BURST_ACTIVE = st_r.active;

endmodule

/* File: test/pbsc_properties.sv */
// port checks of the burst memory control block
`timescale 1ns/10ps
module pbsc_properties (
   input wire logic                  REF_CLK,
   input wire logic                  RST_B,
   input wire logic                  CLOCK_ENABLE_N,
   input wire logic                  CHIP_SELECT_ONE_N,
   input wire logic                  CHIP_SELECT_TWO_N,
   input wire logic                  CHIP_SELECT_TWO,
   input wire logic                  READ_WRITE,
   input wire logic                  ADVANCE_OR_LOAD,
   input wire logic                  DQ_OE_N,
   input wire pbsc_pkg::pbsc_cycle_e CYCLE_KIND,
   input wire logic                  BURST_ACTIVE
);
   logic go;
   logic ld;
   logic sel;
   // decoded cycle conditions
   assign go = !CLOCK_ENABLE_N;
   assign ld = go && !ADVANCE_OR_LOAD;
   assign sel = !CHIP_SELECT_ONE_N && !CHIP_SELECT_TWO_N && CHIP_SELECT_TWO;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   property p_hold;
      CLOCK_ENABLE_N |=> $stable(DQ_OE_N) && $stable(CYCLE_KIND) && $stable(BURST_ACTIVE);
   endproperty
   a_hold: assert property (p_hold) else $error("suspended edge changed outputs");
   property p_desel;
      ld && !sel |=> CYCLE_KIND == pbsc_pkg::CYC_DESELECT && !BURST_ACTIVE;
   endproperty
   a_desel: assert property (p_desel) else $error("deselect not decoded");
   property p_desel_off;
      ld && !sel ##1 go [*2] |=> DQ_OE_N;
   endproperty
   a_desel_off: assert property (p_desel_off) else $error("bus kept after deselect");
   property p_read;
      ld && sel && READ_WRITE ##1 go [*2] |=> !DQ_OE_N;
   endproperty
   a_read: assert property (p_read) else $error("read data not driven");
   property p_load;
      ld && sel |=> BURST_ACTIVE && CYCLE_KIND == ($past(READ_WRITE) ?
         pbsc_pkg::CYC_LOAD_READ : pbsc_pkg::CYC_LOAD_WRITE);
   endproperty
   a_load: assert property (p_load) else $error("load kind wrong");
   property p_adv;
      go && ADVANCE_OR_LOAD && BURST_ACTIVE |=> CYCLE_KIND == pbsc_pkg::CYC_BURST;
   endproperty
   a_adv: assert property (p_adv) else $error("advance not a burst");
   property p_idle_cycle;
      go && ADVANCE_OR_LOAD && !BURST_ACTIVE |=> CYCLE_KIND == pbsc_pkg::CYC_IDLE;
   endproperty
   a_idle_cycle: assert property (p_idle_cycle) else $error("advance without burst not idle");
   property p_pwr;
      $rose(RST_B) |-> DQ_OE_N;
   endproperty
   a_pwr: assert property (p_pwr) else $error("bus driven after power up");
endmodule

bind pbsc_top pbsc_properties chk_u (.REF_CLK(REF_CLK), .RST_B(RST_B),
   .CLOCK_ENABLE_N(CLOCK_ENABLE_N), .CHIP_SELECT_ONE_N(CHIP_SELECT_ONE_N),
   .CHIP_SELECT_TWO_N(CHIP_SELECT_TWO_N), .CHIP_SELECT_TWO(CHIP_SELECT_TWO),
   .READ_WRITE(READ_WRITE), .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD), .DQ_OE_N(DQ_OE_N),
   .CYCLE_KIND(CYCLE_KIND), .BURST_ACTIVE(BURST_ACTIVE));

/* File: test/pbsc_ctl_model.sv */
// controller model driving the burst memory pins
`timescale 1ns/10ps
module pbsc_ctl_model (
   input  wire logic           clk,
   output pbsc_pkg::pbsc_ctl_s ctl,
   output logic [3:0]          bw_n,
   output logic [17:0]         addr,
   output logic [35:0]         dq
);
   logic [36:0] now_r;
   logic [36:0] stg_r;
   // present one command just after an edge
   task automatic cmd(input pbsc_pkg::pbsc_ctl_s c, input logic [3:0] b,
                      input logic [17:0] a, input logic [36:0] w);
      @(posedge clk);
      #1;
      ctl = c;
      bw_n = b;
      addr = a;
      now_r = w;
   endtask
   // idle deselected pins at time zero
   initial begin
      ctl = 7'h34;
      bw_n = 4'hF;
      addr = 18'h0_0000;
      dq = 36'h0_0000_0000;
      now_r = 37'h0_0000_0000;
      stg_r = 37'h0_0000_0000;
   end
   // write data after one more taken edge, else a toggling bus; suspend holds all
   always @(posedge clk) begin
      if (!ctl.clock_enable_n) begin
         dq <= stg_r[36] ? stg_r[35:0] : ~dq;
         stg_r <= now_r;
      end
   end
endmodule

/* File: test/pipelined_burst_sram_control_tb.sv */
// self-checking bench of the burst memory control block
`timescale 1ns/10ps
module pipelined_burst_sram_control_tb;
   logic                REF_CLK = 0;
   logic                RST_B = 0;
   logic                run = 0;
   logic                cq = 1;
   logic                oe_n;
   logic [1:0]          k;
   logic [1:0]          dir = 0;
   logic [3:0]          bw;
   logic [17:0]         ad, a, bs, cur;
   logic [35:0]         dq_in, dq_out;
   logic [36:0]         nt, notes[$];
   logic [35:0]         mem[logic [17:0]];
   logic [31:0]         sd = 75492;
   logic [31:0]         r;
   pbsc_pkg::pbsc_ctl_s c;
   int                  miscompares = 0;
   int                  n_checks = 0;
   always #20 REF_CLK = ~REF_CLK;
   pbsc_ctl_model mdl_u (.clk(REF_CLK), .ctl(c), .bw_n(bw), .addr(ad), .dq(dq_in));
   pbsc_top dut_u (.REF_CLK(REF_CLK), .RST_B(RST_B), .CLOCK_ENABLE_N(c.clock_enable_n),
      .CHIP_SELECT_ONE_N(c.chip_select_one_n), .CHIP_SELECT_TWO_N(c.chip_select_two_n),
      .CHIP_SELECT_TWO(c.chip_select_two), .READ_WRITE(c.read_write),
      .ADVANCE_OR_LOAD(c.advance_or_load), .BURST_ORDER_SELECT(c.burst_order_select),
      .BYTE_WRITE_STROBE_N(bw), .ADDR(ad), .DQ_IN(dq_in), .DQ_OUT(dq_out),
      .DQ_OE_N(oe_n), .CYCLE_KIND(), .BURST_ACTIVE());
   function automatic logic [31:0] rnd();
      sd ^= sd << 13;
      sd ^= sd >> 17;
      sd ^= sd << 5;
      return sd;
   endfunction
   task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
      n_checks++;
      if (e !== s) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // v is suspend, three select-off bits, read, advance, order; notes the bus two edges on
   task automatic step(input logic [6:0] v, input logic [3:0] b, input logic [17:0] x);
      logic [35:0] wd;
      wd = 36'({rnd(), rnd()});
      if (!v[6]) begin
         if (!v[1]) begin
            dir = (v[5:3] != 0) ? 2'd0 : (v[2] ? 2'd1 : 2'd2);
            bs = x;
            cur = x;
            k = 0;
         end else if (dir != 0) begin
            k++;
            cur = {bs[17:2], v[0] ? bs[1:0] ^ k : bs[1:0] + k};
         end
         for (int l = 0; l < 4; l++) if (dir == 2 && !b[l]) mem[cur][9*l+:9] = wd[9*l+:9];
         notes.push_back(dir == 1 ? {1'b0, mem[cur]} : {1'b1, 36'h0_0000_0000});
      end
      mdl_u.cmd({v[6:4], ~v[3], v[2:0]}, b, x, {dir == 2 && !v[6], wd});
      run = 1;
   endtask
   // take the oldest note at each edge that follows a taken edge
   always @(posedge REF_CLK) begin
      if (run && !cq && notes.size() > 0) begin
         nt = notes.pop_front();
         chk("DQ_OE_N", 36'(nt[36]), 36'(oe_n));
         if (!nt[36]) chk("DQ_OUT", nt[35:0], dq_out);
      end
      cq = c.clock_enable_n || !run;
   end
   initial begin
      #400000;
      miscompares++;
      print_verdict;
   end
   // bursts both orders, strobes, selects, suspend, then random traffic
   initial begin
      repeat (16) @(posedge REF_CLK);
      #1;
      RST_B = 1;
      // the two edges around release still show the reset pipeline: bus released
      repeat (2) notes.push_back({1'b1, 36'h0_0000_0000});
      for (int o = 0; o < 2; o++) begin
         a = 18'(rnd());
         step(7'(o), 4'h0, a);
         repeat (5) step(7'h06 | 7'(o), 4'h0, a);
         step(7'h04 | 7'(o), 4'h0, a);
         repeat (5) step(7'h02 | 7'(o), 4'h0, a);
      end
      for (int i = 0; i < 16; i++) begin
         step(7'h00, 4'(i), a);
         step(7'h04, 4'hF, a);
      end
      for (int i = 0; i < 3; i++) begin
         step(7'h04, 4'h0, a);
         step(7'h08 << i, 4'h0, a);
         repeat (2) step(7'h06, 4'h0, a);
      end
      step(7'h04, 4'h0, a);
      step(7'h06, 4'h0, a);
      repeat (2) step(7'h46, 4'h0, a);
      repeat (2) step(7'h06, 4'h0, a);
      repeat (300) begin
         r = rnd();
         step({r[0] & r[1], r[4:2] & {3{r[5]}}, r[8:6]}, r[12:9], {a[17:2], r[14:13]});
      end
      repeat (3) step(7'h38, 4'hF, a);
      // let the last command's data phase reach the watcher
      repeat (5) @(posedge REF_CLK);
      chk("notes left", 36'h0_0000_0000, 36'(notes.size()));
      print_verdict;
   end
endmodule
